// ==== design/lshcr_top.sv ====
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/100ps
module lshcr_top (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic receive_input,
	input wire logic [1:0] cpu_int_mask,
	output logic header_irq,
	output logic baud_tick
);
	import lshcr_pkg::*;

	typedef struct packed {
		lshcr_state_e st;
		logic [7:0] ctrl;
		logic herr;
		logic ferr;
		logic rdrf;
		logic hdf;
		logic sr_read;
		logic [7:0] data;
		logic [7:0] mant_nom;
		logic [3:0] frac_nom;
		logic [11:0] div;
		logic [11:0] meas;
		logic [11:0] acc;
		logic [3:0] smp;
		logic [3:0] bitn;
		logic [7:0] shft;
		logic busy;
		logic rx_d;
		logic [7:0] low_cnt;
		logic [2:0] edges;
		logic [14:0] meas_cnt;
		logic [14:0] seg;
		logic tmo_run;
		logic [3:0] tmo_smp;
		logic [7:0] hbits;
		logic [7:0] hlen;
		logic [7:0] rdata;
		logic irq;
		logic tick;
	} lshcr_regs_s;

	lshcr_regs_s state_r;
	lshcr_regs_s state_nxt;

	////////////////////////////////////////////////////////////
	function automatic logic [11:0] lshcr_absdiff(input logic [11:0] a, input logic [11:0] b);
		lshcr_absdiff = (a > b) ? (a - b) : (b - a);
	endfunction

	// true when |meas-div|/div reaches the deviation limit
	function automatic logic lshcr_dev_bad(input logic [11:0] m, input logic [11:0] d);
		logic [17:0] lhs;
		logic [17:0] rhs;
		lhs = {lshcr_absdiff(m, d), 6'h00};
		rhs = 18'({6'h00, d} * DEV_LIMIT_NUM);
		lshcr_dev_bad = (lhs >= rhs);
	endfunction

	////////////////////////////////////////////////////////////
	always_comb begin
		lshcr_regs_s n;
		logic slave;
		logic fall;
		logic rx;
		logic samp;
		logic char_done;
		logic stop_ok;
		logic brk;
		logic load;
		logic [7:0] load_val;
		logic hdr_err;
		logic blk_err;
		logic tmo;
		logic ars;
		logic hdm;
		logic mute;
		logic sfs_sw_clr;
		logic [12:0] acc_sum;
		logic [11:0] new_meas;
		n = state_r;
		rx = receive_input;
		fall = state_r.rx_d & ~rx;
		n.rx_d = rx;
		char_done = 1'b0;
		stop_ok = 1'b0;
		brk = 1'b0;
		load = 1'b0;
		load_val = 8'h00;
		hdr_err = 1'b0;
		blk_err = 1'b0;
		tmo = 1'b0;
		sfs_sw_clr = 1'b0;
		new_meas = state_r.meas_cnt[14:3];
		n.tick = 1'b0;
		n.rdata = 8'h00;
		ars = state_r.ctrl[CT_ARS];
		hdm = state_r.ctrl[CT_HDM];
		mute = state_r.ctrl[CT_MUTE];
		slave = state_r.ctrl[CT_LINE] & state_r.ctrl[CT_SLV];

		// register port: reads first so hardware sets win
		if (reg_rd) begin
			unique case (reg_addr)
				OFS_STATUS: begin
					n.rdata = {1'b0, state_r.hdf, state_r.rdrf, 1'b0, state_r.herr, 1'b0, state_r.ferr, 1'b0};
					n.sr_read = 1'b1;
				end
				OFS_DATA: begin
					n.rdata = state_r.data;
					if (state_r.sr_read) begin
						// blocked state holds the error until the state bit drops
						if (!state_r.ctrl[CT_SFS])
							n.herr = 1'b0;
						n.ferr = 1'b0;
						n.rdrf = 1'b0;
						n.hdf = 1'b0;
					end
					n.sr_read = 1'b0;
				end
				OFS_CTRL: n.rdata = state_r.ctrl;
				OFS_MANT: n.rdata = state_r.div[11:4];
				OFS_FRAC: n.rdata = {4'h0, state_r.div[3:0]};
				OFS_HLEN: n.rdata = state_r.hlen;
				default: n.rdata = 8'h00;
			endcase
		end
		if (reg_wr && reg_addr == OFS_CTRL) begin
			sfs_sw_clr = state_r.ctrl[CT_SFS] & ~reg_wdata[CT_SFS];
			n.ctrl = reg_wdata;
		end
		if (reg_wr && reg_addr == OFS_FRAC)
			n.frac_nom = reg_wdata[3:0];

		////////////////////////////////////////////////////////
		// fractional sampling clock: one tick every div/16 clocks
		acc_sum = {1'b0, state_r.acc} + {8'h00, SAMPLE_STEP};
		if (slave && state_r.div != 12'h000) begin
			if (acc_sum >= {1'b0, state_r.div}) begin
				n.tick = 1'b1;
				n.acc = 12'(acc_sum - {1'b0, state_r.div});
			end else begin
				n.acc = acc_sum[11:0];
			end
		end else begin
			n.acc = 12'h000;
		end
		samp = n.tick;

		// break: at least 11 low bits then a recessive sample
		if (samp) begin
			if (!rx) begin
				if (state_r.low_cnt != 8'hFF)
					n.low_cnt = state_r.low_cnt + 8'h01;
			end else begin
				brk = (state_r.low_cnt >= BREAK_SAMPLES);
				n.low_cnt = 8'h00;
			end
		end

		// character engine, mid-bit sampling
		if (!state_r.busy) begin
			if (fall) begin
				n.busy = 1'b1;
				n.smp = 4'h0;
				n.bitn = 4'h0;
			end
		end else if (samp) begin
			n.smp = state_r.smp + 4'h1;
			if (state_r.smp == SAMPLE_MID) begin
				n.bitn = state_r.bitn + 4'h1;
				if (state_r.bitn == 4'h0 && rx) begin
					n.busy = 1'b0;
				end else if (state_r.bitn == STOP_BIT_IDX) begin
					n.busy = 1'b0;
					char_done = 1'b1;
					stop_ok = rx;
				end else if (state_r.bitn != 4'h0) begin
					n.shft = {rx, state_r.shft[7:1]};
				end
			end
		end

		// header timeout in slave bit times
		if (state_r.tmo_run && samp) begin
			n.tmo_smp = state_r.tmo_smp + 4'h1;
			if (state_r.tmo_smp == SAMPLE_LAST) begin
				if (state_r.hbits != 8'hFF)
					n.hbits = state_r.hbits + 8'h01;
				if (state_r.hbits == HEADER_MAX_BITS)
					tmo = hdm | ars;
			end
		end

		////////////////////////////////////////////////////////
		unique case (state_r.st)
			LSHCR_HUNT: begin
			end
			LSHCR_SYNCH: begin
				if (ars) begin
					// measurement: the character engine result is dropped
					n.busy = 1'b0;
					if (state_r.edges != 3'h0) begin
						n.meas_cnt = state_r.meas_cnt + 15'h0001;
						n.seg = state_r.seg + 15'h0001;
						if (state_r.meas_cnt == 15'h7FFF)
							blk_err = 1'b1;
					end
					if (fall) begin
						n.edges = state_r.edges + 3'h1;
						n.seg = 15'h0000;
						if (state_r.edges == 3'h0) begin
							n.meas_cnt = 15'h0001;
						end else if (state_r.seg < {3'h0, state_r.div}) begin
							blk_err = 1'b1;
						end
						if (n.edges == SYNCH_EDGES && !blk_err) begin
							if (lshcr_dev_bad(new_meas, state_r.div)) begin
								blk_err = 1'b1;
							end else begin
								n.meas = new_meas;
								if (!state_r.ctrl[CT_DUM])
									n.div = new_meas;
								n.ctrl[CT_SFS] = 1'b0;
								n.st = LSHCR_IDENT;
							end
						end
					end
					if (sfs_sw_clr) begin
						n.tmo_run = 1'b0;
						n.st = LSHCR_HUNT;
					end
				end else if (char_done) begin
					if (!mute && !hdm) begin
						load = 1'b1;
						load_val = state_r.shft;
					end
					if (state_r.shft != SYNCH_PATTERN)
						hdr_err = 1'b1;
					else
						n.st = LSHCR_IDENT;
				end
			end
			LSHCR_IDENT: begin
				if (char_done) begin
					n.tmo_run = 1'b0;
					if (hdm | ars)
						n.hlen = state_r.hbits;
					if (ars && state_r.ctrl[CT_DUM])
						n.div = state_r.meas;
					if (mute && hdm && stop_ok)
						n.ctrl[CT_MUTE] = 1'b0;
					if (!mute || (hdm && stop_ok)) begin
						load = 1'b1;
						load_val = n.shft;
						if (hdm)
							n.hdf = 1'b1;
						if (!stop_ok)
							n.ferr = 1'b1;
					end
					n.st = LSHCR_DATA;
				end
			end
			LSHCR_DATA: begin
				// an all-zero frame is a break and is left to the detector
				if (char_done && !mute && (stop_ok || n.shft != 8'h00)) begin
					load = 1'b1;
					load_val = n.shft;
					if (!stop_ok)
						n.ferr = 1'b1;
				end
			end
			LSHCR_BLOCKED: begin
				n.busy = 1'b0;
				if (!n.ctrl[CT_SFS])
					n.st = LSHCR_HUNT;
			end
		endcase

		// header errors, timeout included, stop the timeout counter
		if (blk_err) begin
			n.herr = 1'b1;
			n.ctrl[CT_SFS] = 1'b1;
			n.tmo_run = 1'b0;
			n.st = LSHCR_BLOCKED;
		end
		if (hdr_err) begin
			n.herr = 1'b1;
			n.tmo_run = 1'b0;
			n.st = LSHCR_HUNT;
		end
		if (tmo && state_r.tmo_run && !blk_err && !hdr_err) begin
			n.herr = 1'b1;
			n.tmo_run = 1'b0;
			n.hlen = n.hbits;
			if (state_r.st == LSHCR_SYNCH && ars) begin
				n.ctrl[CT_SFS] = 1'b1;
				n.st = LSHCR_BLOCKED;
			end else begin
				n.st = LSHCR_HUNT;
			end
		end

		// overrun: a character into a full data register
		if (load) begin
			if (state_r.rdrf)
				n.herr = 1'b1;
			else
				n.data = load_val;
			n.rdrf = 1'b1;
		end

		// a break restarts header handling from any unblocked state
		if (brk && state_r.st != LSHCR_BLOCKED) begin
			n.busy = 1'b0;
			n.edges = 3'h0;
			n.meas_cnt = 15'h0000;
			n.tmo_run = 1'b1;
			n.tmo_smp = 4'h0;
			n.hbits = 8'h00;
			n.st = LSHCR_SYNCH;
			if (ars)
				n.ctrl[CT_SFS] = 1'b1;
			if (!hdm) begin
				n.hdf = 1'b1;
				n.data = 8'h00;
				n.rdrf = 1'b1;
				n.ctrl[CT_MUTE] = 1'b0;
			end
		end

		if (!slave) begin
			n.st = LSHCR_HUNT;
			n.tmo_run = 1'b0;
			n.busy = 1'b0;
		end

		// nominal value written last so it wins the tie
		if (reg_wr && reg_addr == OFS_MANT) begin
			n.mant_nom = reg_wdata;
			n.div = {reg_wdata, state_r.frac_nom};
		end

		n.irq = n.herr & n.ctrl[CT_RXIE] & (cpu_int_mask == 2'h0);
		state_nxt = n;
	end

	////////////////////////////////////////////////////////////
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= '0;
			state_r.st <= LSHCR_HUNT;
			state_r.ctrl <= CTRL_RST;
			state_r.mant_nom <= MANT_RST;
			state_r.frac_nom <= FRAC_RST;
			state_r.div <= DIV_RST;
			state_r.meas <= DIV_RST;
			state_r.rx_d <= 1'b1;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign reg_rdata = state_r.rdata;
	assign header_irq = state_r.irq;
	assign baud_tick = state_r.tick;
endmodule

// ==== design/lshcr_pkg.sv ====
package lshcr_pkg;
	// register offsets on the plain register port
	localparam logic [2:0] OFS_STATUS = 3'h0;
	localparam logic [2:0] OFS_DATA = 3'h1;
	localparam logic [2:0] OFS_CTRL = 3'h2;
	localparam logic [2:0] OFS_MANT = 3'h3;
	localparam logic [2:0] OFS_FRAC = 3'h4;
	localparam logic [2:0] OFS_HLEN = 3'h5;
	// serial_status_reg bit positions
	localparam int ST_HDF = 6;
	localparam int ST_RDRF = 5;
	localparam int ST_HERR = 3;
	localparam int ST_FERR = 1;
	// control register bit positions
	localparam int CT_LINE = 7;
	localparam int CT_SLV = 6;
	localparam int CT_HDM = 5;
	localparam int CT_ARS = 4;
	localparam int CT_SFS = 3;
	localparam int CT_DUM = 2;
	localparam int CT_MUTE = 1;
	localparam int CT_RXIE = 0;
	// reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] MANT_RST = 8'h01;
	localparam logic [3:0] FRAC_RST = 4'h0;
	localparam logic [11:0] DIV_RST = 12'h010;
	// protocol figures
	localparam logic [7:0] SYNCH_PATTERN = 8'h55;
	localparam logic [3:0] SAMPLE_MID = 4'h7;
	localparam logic [3:0] SAMPLE_LAST = 4'hF;
	localparam logic [3:0] STOP_BIT_IDX = 4'h9;
	localparam logic [7:0] BREAK_SAMPLES = 8'hB0;
	localparam logic [7:0] HEADER_MAX_BITS = 8'h39;
	localparam logic [2:0] SYNCH_EDGES = 3'h5;
	localparam logic [4:0] SAMPLE_STEP = 5'h10;
	// deviation limit 10/64 = 15.625%
	localparam logic [17:0] DEV_LIMIT_NUM = 18'h0000A;
	typedef enum logic [2:0] {
		LSHCR_HUNT,
		LSHCR_SYNCH,
		LSHCR_IDENT,
		LSHCR_DATA,
		LSHCR_BLOCKED
	} lshcr_state_e;
endpackage

// ==== verification/lshcr_lin_master.sv ====
`timescale 1ns/100ps
// lin master node: drives the bus, recessive (pulled up) between fields
module lshcr_lin_master (
	input wire logic clock,
	output logic line
);
	int bit_cyc = 16;
	initial line = 1'b1;
	////////////////////////////////////////
	// level for n bit times, changed just after an edge
	task automatic hold(input logic lv, input int n);
		@(posedge clock);
		line <= lv;
		repeat (n * bit_cyc - 1) @(posedge clock);
	endtask
	// 13 dominant bits leave margin over the 11-bit minimum for a slow slave
	task automatic brk();
		hold(1'b0, 13);
		hold(1'b1, 1);
	endtask
	// start, 8 bits lsb first, stop, one idle bit
	task automatic byte_tx(input logic [7:0] b);
		hold(1'b0, 1);
		for (int i = 0; i < 8; i++) hold(b[i], 1);
		hold(1'b1, 2);
	endtask
endmodule

// ==== verification/lshcr_top_chk.sv ====
`timescale 1ns/100ps
module lshcr_top_chk
	import lshcr_pkg::*;
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic receive_input,
	input wire logic [1:0] cpu_int_mask,
	input wire logic header_irq,
	input wire logic baud_tick
);
	logic slave_r;
	wire logic data_rd = reg_rd && reg_addr == OFS_DATA;
	// slave mode bits are software only, so a write shadow is exact
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) slave_r <= 1'b0;
		else if (reg_wr && reg_addr == OFS_CTRL) slave_r <= reg_wdata[CT_LINE] & reg_wdata[CT_SLV];
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	////////////////////////////////////////
	irq_masked_a: assert property ($past(cpu_int_mask) != 2'h0 |-> !header_irq)
		else $error("header irq with cpu mask set");
	// either lag is allowed for the clear to reach the irq
	irq_fall_a: assert property ($fell(header_irq) |-> $past(data_rd) || $past(data_rd, 2) ||
		$past(reg_wr) || $past(reg_wr, 2) || $past(cpu_int_mask) != 2'h0)
		else $error("header irq dropped without clear sequence");
	master_quiet_a: assert property (!slave_r && !$past(slave_r) |-> !baud_tick)
		else $error("baud tick outside slave mode");
	mant_back_a: assert property (reg_wr && reg_addr == OFS_MANT ##2 reg_rd && reg_addr == OFS_MANT
		|=> reg_rdata == $past(reg_wdata, 3))
		else $error("mantissa write not active");
	frac_back_a: assert property (reg_wr && reg_addr == OFS_FRAC ##2 reg_wr && reg_addr == OFS_MANT
		##2 reg_rd && reg_addr == OFS_FRAC |=> reg_rdata == $past(reg_wdata, 5))
		else $error("fraction not moved with mantissa");
	unmapped_rd_a: assert property (reg_rd && reg_addr > 3'h5 |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside read cycle");
	status_rsv_a: assert property (reg_rd && reg_addr == OFS_STATUS |=> (reg_rdata & 8'h95) == 8'h00)
		else $error("unused status bit set");
	cover property ($rose(header_irq));
	cover property (baud_tick && slave_r);
	cover property (reg_rd && reg_addr == OFS_HLEN);
endmodule
bind lshcr_top lshcr_top_chk lshcr_top_chk_inst (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.receive_input(receive_input), .cpu_int_mask(cpu_int_mask), .header_irq(header_irq),
	.baud_tick(baud_tick));

// ==== verification/tb_lshcr_top.sv ====
`timescale 1ns/100ps
module tb_lshcr_top;
	import lshcr_pkg::*;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [1:0] cpu_int_mask = 2'h1;
	wire logic [7:0] reg_rdata;
	wire logic receive_input;
	wire logic header_irq;
	wire logic baud_tick;
	logic [7:0] v;
	int n_errors = 0;
	int checks = 0;
	int c;
	lshcr_top lshcr_top_inst (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .receive_input(receive_input),
		.cpu_int_mask(cpu_int_mask), .header_irq(header_irq), .baud_tick(baud_tick));
	lshcr_lin_master lshcr_lin_master_inst (.clock(clock), .line(receive_input));
	initial begin
		forever #2.5 clock = ~clock;
	end
	////////////////////////////////////////
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		v = reg_rdata;
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic bits(input int n);
		repeat (n * 16) @(posedge clock);
	endtask
	task automatic count(input int n);
		wt(4);
		c = 0;
		repeat (n) begin
			wt(1);
			if (baud_tick === 1'b1) c++;
		end
	endtask
	task automatic hdr(input logic [7:0] s);
		lshcr_lin_master_inst.brk();
		lshcr_lin_master_inst.byte_tx(s);
		lshcr_lin_master_inst.byte_tx(8'h3C);
		bits(2);
	endtask
	task automatic irq_is(input logic [7:0] e);
		wt(3);
		chk("header_irq", {7'h00, header_irq}, e);
	endtask
	task automatic final_report();
		if (n_errors == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// about ten times the expected run
	initial begin
		#300000;
		n_errors++;
		final_report();
	end
	initial begin
		repeat (6) @(posedge clock);
		reset_n <= 1'b1;
		rd(OFS_CTRL);
		chk("ctrl reset", v, CTRL_RST);
		rd(OFS_MANT);
		chk("mant reset", v, MANT_RST);
		rd(3'h6);
		chk("unmapped", v, 8'h00);
		wr(OFS_FRAC, 8'h03);
		wr(OFS_MANT, 8'h01);
		rd(OFS_FRAC);
		chk("frac copy", v, 8'h03);
		wr(OFS_FRAC, 8'h00);
		wr(OFS_MANT, 8'h02);
		rd(OFS_MANT);
		chk("mant copy", v, 8'h02);
		count(64);
		chk("master ticks", 8'(c), 8'h00);
		wr(OFS_CTRL, 8'hC0);
		count(64);
		chk("slave ticks", 8'(c), 8'h20);
		wr(OFS_MANT, 8'h01);
		// wrong synch byte, irq held off by the cpu mask
		wr(OFS_CTRL, 8'hE1);
		hdr(8'h00);
		irq_is(8'h00);
		@(posedge clock);
		cpu_int_mask <= 2'h0;
		irq_is(8'h01);
		rd(OFS_DATA);
		irq_is(8'h01);
		rd(OFS_STATUS);
		chk("synch error", v & 8'h08, 8'h08);
		rd(OFS_DATA);
		irq_is(8'h00);
		// break alone: no error up to 57 bits, error past it
		lshcr_lin_master_inst.brk();
		bits(56);
		rd(OFS_STATUS);
		chk("early timeout", v & 8'h08, 8'h00);
		bits(6);
		rd(OFS_STATUS);
		chk("timeout", v & 8'h08, 8'h08);
		rd(OFS_DATA);
		lshcr_lin_master_inst.brk();
		lshcr_lin_master_inst.byte_tx(8'h55);
		rd(OFS_STATUS);
		chk("hdf early", v & 8'h40, 8'h00);
		lshcr_lin_master_inst.byte_tx(8'h3C);
		bits(2);
		rd(OFS_STATUS);
		chk("hdf late", v & 8'h48, 8'h40);
		rd(OFS_DATA);
		chk("ident", v, 8'h3C);
		rd(OFS_HLEN);
		chk("hlen", {7'h00, v > 8'h00 && v <= HEADER_MAX_BITS}, 8'h01);
		// master 12.5% slow: measured 8 bits of 18 cycles gives 1.125
		wr(OFS_CTRL, 8'hF1);
		lshcr_lin_master_inst.bit_cyc = 18;
		hdr(8'h55);
		rd(OFS_MANT);
		chk("resync mant", v, 8'h01);
		rd(OFS_FRAC);
		chk("resync frac", v, 8'h02);
		rd(OFS_STATUS);
		chk("resync ok", v & 8'h08, 8'h00);
		rd(OFS_DATA);
		chk("no synch char", v, 8'h3C);
		wr(OFS_MANT, 8'h01);
		rd(OFS_FRAC);
		chk("nominal back", v, 8'h00);
		// update method 1: the measured value waits for the identifier
		wr(OFS_CTRL, 8'hF5);
		lshcr_lin_master_inst.brk();
		lshcr_lin_master_inst.byte_tx(8'h55);
		rd(OFS_FRAC);
		chk("held update", v, 8'h00);
		lshcr_lin_master_inst.byte_tx(8'h3C);
		bits(2);
		rd(OFS_FRAC);
		chk("late update", v, 8'h02);
		rd(OFS_STATUS);
		rd(OFS_DATA);
		wr(OFS_MANT, 8'h01);
		// master 25% slow: deviation blocks in synch state
		lshcr_lin_master_inst.bit_cyc = 20;
		hdr(8'h55);
		rd(OFS_CTRL);
		chk("blocked", v & 8'h08, 8'h08);
		rd(OFS_STATUS);
		chk("deviation", v & 8'h08, 8'h08);
		rd(OFS_DATA);
		irq_is(8'h01);
		wr(OFS_CTRL, 8'hF1);
		rd(OFS_STATUS);
		rd(OFS_DATA);
		irq_is(8'h00);
		// mute: a bad synch keeps muting, a good header wakes
		lshcr_lin_master_inst.bit_cyc = 16;
		wr(OFS_MANT, 8'h01);
		wr(OFS_CTRL, 8'hE3);
		hdr(8'h00);
		rd(OFS_CTRL);
		chk("mute kept", v & 8'h02, 8'h02);
		rd(OFS_STATUS);
		chk("mute error", v & 8'h08, 8'h08);
		rd(OFS_DATA);
		hdr(8'h55);
		rd(OFS_CTRL);
		chk("woken", v & 8'h02, 8'h00);
		final_report();
	end
endmodule
